// [include/psj_regs.svh]
// Timing counts, command bytes and reply bit positions for the pad bridge
`ifndef PSJ_REGS_SVH
`define PSJ_REGS_SVH

`define PSJ_MCLK_PERIOD_NS 10
`define PSJ_LINK_PERIOD_NS 160
`define PSJ_BIT_HALF_NS 2000
`define PSJ_BIT_HALF_CYC (`PSJ_BIT_HALF_NS / `PSJ_LINK_PERIOD_NS)
`define PSJ_ACK_TMO_NS 100000
`define PSJ_ACK_TMO_CYC (`PSJ_ACK_TMO_NS / `PSJ_LINK_PERIOD_NS)
`define PSJ_POLL_HZ 50
`define PSJ_POLL_CYC (1000000000 / (`PSJ_POLL_HZ * `PSJ_MCLK_PERIOD_NS))

`define PSJ_NUM_BYTES 5
`define PSJ_CMD_START 8'h01
`define PSJ_CMD_POLL 8'h42
`define PSJ_CMD_IDLE 8'h00
`define PSJ_READY_MARK 8'h5A

`define PSJ_BTN_RESET 16'hFFFF
`define PSJ_BIT_UP 4
`define PSJ_BIT_RIGHT 5
`define PSJ_BIT_DOWN 6
`define PSJ_BIT_LEFT 7
`define PSJ_BIT_TRI 12
`define PSJ_BIT_CIRCLE 13
`define PSJ_BIT_CROSS 14
`define PSJ_BIT_SQUARE 15

`endif

// [include/psj_pkg.sv]
// Types shared by the pad bridge
package psj_pkg;
    typedef enum logic [5:0] {
        L_IDLE  = 6'h01,
        L_SETUP = 6'h02,
        L_LOW   = 6'h04,
        L_HIGH  = 6'h08,
        L_ACK   = 6'h10,
        L_END   = 6'h20
    } psj_link_e;
    typedef logic [7:0] psj_byte_t;
    typedef logic [1:0] psj_phase_t;
endpackage

// [rtl/psj_sync.sv]
// Two-stage synchroniser for a group of single-bit levels
`timescale 1ns/1ps
module psj_sync #(
    parameter int W = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            q <= '1;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

// [rtl/psj_top.sv]
// Pad serial bus host bridged to active-low joystick and quadrature mouse pins
//
// Summary of operation
// - Asserted joystick direction and button lines are pulled low.
// - Each joystick output is strictly asserted or released, nothing between.
// - Joystick side has no protocol; lines follow current switch state.
// - Primary fire always sits on connector position six.
// - A second fire output is provided on position nine.
// - Mouse quadrature is identical for both maps; only pin placement differs.
// - Shared bus lines, one select per pad; only the selected pad answers.
// - Host drives the pad select as chip select during an exchange.
// - Command bytes are eight bits, least significant bit first.
// - Select, bit clock and handshake are active low for both parties.
// - Command and reply bits move on the same clock pulses.
// - Only the pad drives reply and handshake; host drives the rest.
// - Bit clock is about 250 kHz, inside the 100 to 500 kHz range.
// - Pad is polled about fifty times per second.
`timescale 1ns/1ps
`include "psj_regs.svh"
module psj_top
    import psj_pkg::*;
#(
    parameter int unsigned POLL_CYCLES = `PSJ_POLL_CYC
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pad bus link clock
    input wire logic link_clk,
    // Pad bus
    output logic pad_select_n,
    output logic pad_clk_n,
    output logic pad_cmd,
    input wire logic pad_reply_line,
    input wire logic pad_ack_n,
    // Mode straps
    input wire logic mode_mouse,
    input wire logic mouse_alt_map,
    input wire logic fire3_en,
    // Joystick connector positions
    output logic jp_pin1_n,
    output logic jp_pin2_n,
    output logic jp_pin3_n,
    output logic jp_pin4_n,
    output logic jp_pin5_n,
    output logic jp_pin6_n,
    output logic jp_pin9_n
);
    localparam logic [9:0] HALF_C = 10'(`PSJ_BIT_HALF_CYC);
    localparam logic [9:0] ACK_TMO_C = 10'(`PSJ_ACK_TMO_CYC);
    localparam logic [2:0] LAST_BYTE_C = 3'(`PSJ_NUM_BYTES - 1);
    localparam logic [20:0] POLL_LAST_C = 21'(POLL_CYCLES - 1);

    function automatic psj_byte_t cmd_byte(input logic [2:0] idx);
        if (idx == 3'h0) begin
            cmd_byte = `PSJ_CMD_START;
        end else if (idx == 3'h1) begin
            cmd_byte = `PSJ_CMD_POLL;
        end else begin
            cmd_byte = `PSJ_CMD_IDLE;
        end
    endfunction

    // Binary phase count to Gray-coded quadrature pair {A, B}
    function automatic logic [1:0] quad(input psj_phase_t ph);
        quad = {ph[1], ph[1] ^ ph[0]};
    endfunction

    // ---------------- Link clock domain ----------------
    logic req_tg_q;
    logic [2:0] lk_sync;
    logic req_s;
    logic reply_s;
    logic ack_s;

    // Reply and handshake are pad-driven, request crosses from mclk
    psj_sync #(.W(3)) u_lk_sync (
        .clk(link_clk),
        .rst_n(rst_n),
        .d({req_tg_q, pad_reply_line, pad_ack_n}),
        .q(lk_sync)
    );
    assign req_s = lk_sync[2];
    assign reply_s = lk_sync[1];
    assign ack_s = lk_sync[0];

    psj_link_e st_q, st_d;
    logic [9:0] cnt_q, cnt_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    psj_byte_t cur_q, cur_d;
    psj_byte_t rx_q, rx_d;
    logic sel_n_q, sel_n_d;
    logic clk_n_q, clk_n_d;
    logic cmd_q, cmd_d;
    logic req_seen_q, req_seen_d;
    logic [15:0] sh_btn_q, sh_btn_d;
    logic sh_ok_q, sh_ok_d;
    logic [15:0] res_btn_q, res_btn_d;
    logic res_ok_q, res_ok_d;
    logic done_tg_q, done_tg_d;
    psj_byte_t exp_cmd;

    assign exp_cmd = cmd_byte(byte_q);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 10'h001;
        bit_d = bit_q;
        byte_d = byte_q;
        cur_d = cur_q;
        rx_d = rx_q;
        sel_n_d = sel_n_q;
        clk_n_d = clk_n_q;
        cmd_d = cmd_q;
        req_seen_d = req_seen_q;
        sh_btn_d = sh_btn_q;
        sh_ok_d = sh_ok_q;
        res_btn_d = res_btn_q;
        res_ok_d = res_ok_q;
        done_tg_d = done_tg_q;
        case (st_q)
            L_IDLE: begin
                cnt_d = 10'h000;
                sel_n_d = 1'b1;
                clk_n_d = 1'b1;
                if (req_s != req_seen_q) begin
                    req_seen_d = req_s;
                    sel_n_d = 1'b0;
                    byte_d = 3'h0;
                    cur_d = cmd_byte(3'h0);
                    sh_ok_d = 1'b1;
                    st_d = L_SETUP;
                end
            end
            L_SETUP: begin
                if (cnt_q == HALF_C - 10'h001) begin
                    cnt_d = 10'h000;
                    bit_d = 3'h0;
                    clk_n_d = 1'b0;
                    cmd_d = cur_q[0];
                    st_d = L_LOW;
                end
            end
            L_LOW: begin
                if (cnt_q == HALF_C - 10'h001) begin
                    cnt_d = 10'h000;
                    clk_n_d = 1'b1;
                    rx_d = {reply_s, rx_q[7:1]};
                    st_d = L_HIGH;
                end
            end
            L_HIGH: begin
                if (cnt_q == HALF_C - 10'h001) begin
                    cnt_d = 10'h000;
                    if (bit_q == 3'h7) begin
                        st_d = L_ACK;
                        if (byte_q == 3'h2 && rx_q != `PSJ_READY_MARK) begin
                            sh_ok_d = 1'b0;
                        end
                        if (byte_q == 3'h3) begin
                            sh_btn_d[7:0] = rx_q;
                        end
                        if (byte_q == 3'h4) begin
                            sh_btn_d[15:8] = rx_q;
                        end
                    end else begin
                        bit_d = bit_q + 3'h1;
                        clk_n_d = 1'b0;
                        cmd_d = cur_q[bit_q + 3'h1];
                        st_d = L_LOW;
                    end
                end
            end
            L_ACK: begin
                // A missing handshake mid-packet means no pad is fitted
                if (!ack_s) begin
                    cnt_d = 10'h000;
                    if (byte_q == LAST_BYTE_C) begin
                        st_d = L_END;
                    end else begin
                        byte_d = byte_q + 3'h1;
                        cur_d = cmd_byte(byte_q + 3'h1);
                        st_d = L_SETUP;
                    end
                end else if (cnt_q == ACK_TMO_C - 10'h001) begin
                    if (byte_q != LAST_BYTE_C) begin
                        sh_ok_d = 1'b0;
                    end
                    st_d = L_END;
                end
            end
            L_END: begin
                sel_n_d = 1'b1;
                res_btn_d = sh_btn_q;
                res_ok_d = sh_ok_q;
                done_tg_d = ~done_tg_q;
                st_d = L_IDLE;
            end
            default: begin
                st_d = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= L_IDLE;
            cnt_q <= 10'h000;
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            cur_q <= 8'h00;
            rx_q <= 8'h00;
            sel_n_q <= 1'b1;
            clk_n_q <= 1'b1;
            cmd_q <= 1'b1;
            req_seen_q <= 1'b1;
            sh_btn_q <= `PSJ_BTN_RESET;
            sh_ok_q <= 1'b0;
            res_btn_q <= `PSJ_BTN_RESET;
            res_ok_q <= 1'b0;
            done_tg_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            cur_q <= cur_d;
            rx_q <= rx_d;
            sel_n_q <= sel_n_d;
            clk_n_q <= clk_n_d;
            cmd_q <= cmd_d;
            req_seen_q <= req_seen_d;
            sh_btn_q <= sh_btn_d;
            sh_ok_q <= sh_ok_d;
            res_btn_q <= res_btn_d;
            res_ok_q <= res_ok_d;
            done_tg_q <= done_tg_d;
        end
    end

    assign pad_select_n = sel_n_q;
    assign pad_clk_n = clk_n_q;
    assign pad_cmd = cmd_q;

    // ---------------- System clock domain ----------------
    logic [3:0] mc_sync;
    logic done_s;
    logic mouse_s;
    logic alt_s;
    logic f3_s;

    psj_sync #(.W(4)) u_mc_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .d({done_tg_q, ~mode_mouse, ~mouse_alt_map, ~fire3_en}),
        .q(mc_sync)
    );
    // Straps travel inverted so the all-ones reset reads as joystick mode,
    // otherwise the mouse map would pull pins low right after reset
    assign done_s = mc_sync[3];
    assign mouse_s = ~mc_sync[2];
    assign alt_s = ~mc_sync[1];
    assign f3_s = ~mc_sync[0];

    logic [20:0] poll_q, poll_d;
    logic busy_q, busy_d;
    logic req_tg_d;
    logic done_seen_q, done_seen_d;
    logic [15:0] btn_q, btn_d;
    logic ok_q, ok_d;
    psj_phase_t xph_q, xph_d, yph_q, yph_d;
    logic [6:0] pin_q, pin_d;
    logic [15:0] prs;
    logic [1:0] qx;
    logic [1:0] qy;

    // Result words are held still by the link until the next request,
    // and a request is only issued once the previous result was taken
    always_comb begin
        poll_d = poll_q + 21'h000001;
        busy_d = busy_q;
        req_tg_d = req_tg_q;
        done_seen_d = done_seen_q;
        btn_d = btn_q;
        ok_d = ok_q;
        xph_d = xph_q;
        yph_d = yph_q;
        if (poll_q == POLL_LAST_C) begin
            poll_d = 21'h000000;
            if (!busy_q) begin
                req_tg_d = ~req_tg_q;
                busy_d = 1'b1;
            end
        end
        if (done_s != done_seen_q) begin
            done_seen_d = done_s;
            busy_d = 1'b0;
            btn_d = res_btn_q;
            ok_d = res_ok_q;
            // Pointer moves one quadrature step per poll
            if (res_ok_q && !res_btn_q[`PSJ_BIT_RIGHT]) begin
                xph_d = xph_q + 2'h1;
            end else if (res_ok_q && !res_btn_q[`PSJ_BIT_LEFT]) begin
                xph_d = xph_q - 2'h1;
            end
            if (res_ok_q && !res_btn_q[`PSJ_BIT_DOWN]) begin
                yph_d = yph_q + 2'h1;
            end else if (res_ok_q && !res_btn_q[`PSJ_BIT_UP]) begin
                yph_d = yph_q - 2'h1;
            end
        end
    end

    // Pin order in pin_q: {9, 6, 5, 4, 3, 2, 1}
    always_comb begin
        prs = ok_q ? ~btn_q : 16'h0000;
        qx = quad(xph_q);
        qy = quad(yph_q);
        pin_d = 7'h7F;
        if (!mouse_s) begin
            pin_d[0] = ~prs[`PSJ_BIT_UP];
            pin_d[1] = ~prs[`PSJ_BIT_DOWN];
            pin_d[2] = ~prs[`PSJ_BIT_LEFT];
            pin_d[3] = ~prs[`PSJ_BIT_RIGHT];
            pin_d[4] = f3_s ? ~prs[`PSJ_BIT_TRI] : 1'b1;
        end else if (!alt_s) begin
            pin_d[0] = qx[0];
            pin_d[1] = qx[1];
            pin_d[2] = qy[1];
            pin_d[3] = qy[0];
        end else begin
            pin_d[0] = qy[1];
            pin_d[1] = qx[1];
            pin_d[2] = qy[0];
            pin_d[3] = qx[0];
            pin_d[4] = f3_s ? ~prs[`PSJ_BIT_CIRCLE] : 1'b1;
        end
        pin_d[5] = ~prs[`PSJ_BIT_CROSS];
        pin_d[6] = ~prs[`PSJ_BIT_SQUARE];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            poll_q <= 21'h000000;
            busy_q <= 1'b0;
            req_tg_q <= 1'b1;
            done_seen_q <= 1'b1;
            btn_q <= `PSJ_BTN_RESET;
            ok_q <= 1'b0;
            xph_q <= 2'h0;
            yph_q <= 2'h0;
            pin_q <= 7'h7F;
        end else begin
            poll_q <= poll_d;
            busy_q <= busy_d;
            req_tg_q <= req_tg_d;
            done_seen_q <= done_seen_d;
            btn_q <= btn_d;
            ok_q <= ok_d;
            xph_q <= xph_d;
            yph_q <= yph_d;
            pin_q <= pin_d;
        end
    end

    assign jp_pin1_n = pin_q[0];
    assign jp_pin2_n = pin_q[1];
    assign jp_pin3_n = pin_q[2];
    assign jp_pin4_n = pin_q[3];
    assign jp_pin5_n = pin_q[4];
    assign jp_pin6_n = pin_q[5];
    assign jp_pin9_n = pin_q[6];

    // ---------------- Checks ----------------
    property p_clk_in_select;
        @(posedge link_clk) disable iff (!rst_n) !clk_n_q |-> !sel_n_q;
    endproperty
    a_clk_in_select: assert property (p_clk_in_select) else $error("clock without select");

    property p_idle_levels;
        @(posedge link_clk) disable iff (!rst_n) (st_q == L_IDLE) |-> (sel_n_q && clk_n_q);
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("bus not idle high");

    property p_half_low;
        @(posedge link_clk) disable iff (!rst_n) $fell(clk_n_q) |-> !clk_n_q [*8];
    endproperty
    a_half_low: assert property (p_half_low) else $error("bit clock low too short");

    property p_half_exact;
        @(posedge link_clk) disable iff (!rst_n) $fell(clk_n_q) |-> ##12 clk_n_q;
    endproperty
    a_half_exact: assert property (p_half_exact) else $error("bit clock half wrong");

    property p_lsb_first;
        @(posedge link_clk) disable iff (!rst_n) (st_q == L_LOW) |-> pad_cmd == exp_cmd[bit_q];
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("command bit order");

    property p_duplex;
        @(posedge link_clk) disable iff (!rst_n) $rose(clk_n_q) |-> rx_q[7] == $past(reply_s);
    endproperty
    a_duplex: assert property (p_duplex) else $error("reply not sampled on edge");

    property p_release;
        @(posedge link_clk) disable iff (!rst_n) (st_q == L_END) |=> sel_n_q [*2];
    endproperty
    a_release: assert property (p_release) else $error("select held after end");

    property p_fire1;
        @(posedge mclk) disable iff (!rst_n) (ok_q && !btn_q[`PSJ_BIT_CROSS]) |=> !jp_pin6_n;
    endproperty
    a_fire1: assert property (p_fire1) else $error("fire one not on pin six");

    property p_fire2;
        @(posedge mclk) disable iff (!rst_n) (ok_q && !btn_q[`PSJ_BIT_SQUARE]) |=> !jp_pin9_n;
    endproperty
    a_fire2: assert property (p_fire2) else $error("fire two missing");

    property p_up_low;
        @(posedge mclk) disable iff (!rst_n)
            (!mouse_s && ok_q && !btn_q[`PSJ_BIT_UP]) |=> !jp_pin1_n;
    endproperty
    a_up_low: assert property (p_up_low) else $error("up not pulled low");

    property p_absent;
        @(posedge mclk) disable iff (!rst_n) (!ok_q && !mouse_s) |=> (pin_q == 7'h7F);
    endproperty
    a_absent: assert property (p_absent) else $error("released line driven low");

    property p_quad_x;
        @(posedge mclk) disable iff (!rst_n) mouse_s |=> jp_pin2_n == $past(qx[1]);
    endproperty
    a_quad_x: assert property (p_quad_x) else $error("quadrature mismatch");

    property p_poll_tick;
        @(posedge mclk) disable iff (!rst_n) $changed(req_tg_q) |-> poll_q == 21'h000000;
    endproperty
    a_poll_tick: assert property (p_poll_tick) else $error("poll off schedule");

    c_exchange_ok: cover property (@(posedge link_clk) disable iff (!rst_n)
        (st_q == L_END) && sh_ok_q);
    c_pad_absent: cover property (@(posedge link_clk) disable iff (!rst_n)
        (st_q == L_END) && !sh_ok_q);
    c_mouse_step: cover property (@(posedge mclk) disable iff (!rst_n)
        mouse_s && $changed(xph_q));
endmodule

// [dv/psj_pad_model.sv]
// Behavioural game pad that answers the bridge on the pad bus
`timescale 1ns/1ps
`include "psj_regs.svh"
module psj_pad_model (
    // Bus from the bridge
    input wire logic sel_n,
    input wire logic clk_n,
    input wire logic cmd,
    // Bus to the bridge
    output logic reply,
    output logic ack_n,
    // Scenario controls
    input wire logic [15:0] buttons,
    input wire logic skip_ack1,
    input wire logic [15:0] ack_delay_ns,
    // Observation
    output logic [39:0] cmd_log,
    output logic [2:0] nbytes
);
    localparam int BitNs = 2 * `PSJ_BIT_HALF_CYC * `PSJ_LINK_PERIOD_NS;
    logic [7:0] tx;
    logic [7:0] rx;
    // Data and handshake lines have pull-ups, so released means high
    initial begin
        reply = 1'b1;
        ack_n = 1'b1;
        cmd_log = '0;
        nbytes = '0;
    end
    always begin
        @(negedge sel_n);
        nbytes = '0;
        cmd_log = '0;
        for (int i = 0; i < `PSJ_NUM_BYTES; i++) begin
            case (i)
                0: tx = 8'hFF;
                1: tx = 8'h41;
                2: tx = `PSJ_READY_MARK;
                3: tx = buttons[7:0];
                default: tx = buttons[15:8];
            endcase
            for (int b = 0; b < 8; b++) begin
                @(negedge clk_n or posedge sel_n);
                if (sel_n) break;
                reply = tx[b]; // Only the selected pad answers, LSB first
                @(posedge clk_n or posedge sel_n);
                if (sel_n) break;
                rx[b] = cmd; // Command bit taken on the same pulse
            end
            if (sel_n) break;
            cmd_log[8*i +: 8] = rx;
            nbytes = nbytes + 3'd1;
            #(BitNs / 4) reply = 1'b1;
            // Pulse runs in parallel so the next falling clock edge is not missed
            if (!(skip_ack1 && i == 1)) begin
                fork
                    begin
                        #(ack_delay_ns) ack_n = 1'b0; // Active low, one bit period
                        #(BitNs) ack_n = 1'b1;
                    end
                join_none
            end
        end
        reply = 1'b1;
        if (!sel_n) @(posedge sel_n);
    end
endmodule

// [dv/psj_top_test.sv]
// Self-checking bench for the pad bridge with a behavioural pad
`timescale 1ns/1ps
module psj_top_test;
    typedef struct packed {
        logic mouse;
        logic [2:0] nb;
        logic [6:0] pins;
    } psj_note_s;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_mouse = 1'b0;
    logic mouse_alt_map = 1'b0;
    logic fire3_en = 1'b0;
    logic [15:0] buttons = 16'hFFFF;
    logic skip_ack1 = 1'b0;
    logic [15:0] ack_dly = 16'd300;
    logic sel_n, clk_n, cmd, reply, ack_n;
    logic [6:0] pins; // pin9, pin6, pin5, pin4, pin3, pin2, pin1
    logic [39:0] cmd_log;
    logic [2:0] nbytes;
    psj_note_s notes[$];
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        #3;
        forever #80 link_clk = ~link_clk;
    end

    psj_top #(.POLL_CYCLES(19000)) i_psj_top (
        .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
        .pad_select_n(sel_n), .pad_clk_n(clk_n), .pad_cmd(cmd),
        .pad_reply_line(reply), .pad_ack_n(ack_n),
        .mode_mouse(mode_mouse), .mouse_alt_map(mouse_alt_map), .fire3_en(fire3_en),
        .jp_pin1_n(pins[0]), .jp_pin2_n(pins[1]), .jp_pin3_n(pins[2]),
        .jp_pin4_n(pins[3]), .jp_pin5_n(pins[4]), .jp_pin6_n(pins[5]),
        .jp_pin9_n(pins[6])
    );
    psj_pad_model i_psj_pad_model (
        .sel_n(sel_n), .clk_n(clk_n), .cmd(cmd), .reply(reply), .ack_n(ack_n),
        .buttons(buttons), .skip_ack1(skip_ack1), .ack_delay_ns(ack_dly),
        .cmd_log(cmd_log), .nbytes(nbytes)
    );

    task automatic check_pins(input string name, input logic [6:0] exp, input logic [6:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_bytes(input string name, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("Checks: %0d, mismatches: %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [6:0] joy_pins(input logic [15:0] b, input logic f3);
        return {b[15], b[14], f3 ? b[12] : 1'b1, b[5], b[7], b[6], b[4]};
    endfunction
    // Quadrature pairs as (A, B) for each pin map
    function automatic logic [1:0] xpair(input logic mb);
        return mb ? {pins[1], pins[3]} : {pins[1], pins[0]};
    endfunction
    function automatic logic [1:0] ypair(input logic mb);
        return mb ? {pins[0], pins[2]} : {pins[2], pins[3]};
    endfunction

    task automatic run(input string name, input logic [15:0] btn, input logic mm, input logic mb,
                       input logic f3, input logic nack, input logic [15:0] dly);
        psj_note_s n;
        @(posedge mclk);
        #1;
        buttons = btn;
        mode_mouse = mm;
        mouse_alt_map = mb;
        fire3_en = f3;
        skip_ack1 = nack;
        ack_dly = dly;
        n.mouse = mm;
        n.nb = nack ? 3'd2 : 3'd5;
        n.pins = nack ? 7'h7F : joy_pins(btn, f3);
        // Mouse maps: only map B with fire3 on carries the middle button
        if (mm) begin
            n.pins[4] = (mb && f3) ? btn[13] : 1'b1;
        end
        notes.push_back(n);
        @(posedge sel_n);
        repeat (20) @(posedge mclk);
        $display("Test %s done, %0d mismatches so far", name, num_errors);
    endtask

    // Watches each exchange and checks the pins once the result has landed
    initial begin : monitor
        psj_note_s n;
        logic [1:0] x0;
        logic [1:0] y0;
        forever begin
            @(negedge sel_n);
            x0 = xpair(mouse_alt_map);
            y0 = ypair(mouse_alt_map);
            @(posedge sel_n);
            check_pins("idle bit clock", 7'h01, {6'h00, clk_n});
            repeat (10) @(posedge mclk);
            n = notes.pop_front();
            check_bytes("command bytes", 40'h0000004201, cmd_log);
            check_pins("byte count", {4'h0, n.nb}, {4'h0, nbytes});
            if (n.mouse) begin
                check_pins("mouse buttons", {n.pins[6:4], 4'h0}, {pins[6:4], 4'h0});
                check_pins("x step", {5'h00, x0[0], ~x0[1]}, {5'h00, xpair(mouse_alt_map)});
                check_pins("y hold", {5'h00, y0}, {5'h00, ypair(mouse_alt_map)});
            end else begin
                check_pins("joystick pins", n.pins, pins);
            end
        end
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 150000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin : main
        logic [15:0] r;
        void'($urandom(32'hC1E726E0));
        // Reset is asynchronous in both domains, so ten system clocks suffice
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        r = 16'($urandom);
        run("fire3 on slow ack", r & 16'hAFEF, 1'b0, 1'b0, 1'b1, 1'b0, 16'd5000);
        run("missing ack", 16'h0000, 1'b0, 1'b0, 1'b1, 1'b1, 16'd300);
        r = 16'($urandom);
        run("fire3 off", r & 16'h6FBF, 1'b0, 1'b0, 1'b0, 1'b0, 16'd300);
        r = 16'($urandom);
        run("mouse map A", {r[15:13], 13'h1FDF}, 1'b1, 1'b0, 1'b1, 1'b0, 16'h012C);
        r = 16'($urandom);
        run("mouse map B", {r[15:13], 13'h1FDF}, 1'b1, 1'b1, 1'b1, 1'b0, 16'h012C);
        end_of_test();
    end
endmodule
